// [scpc_pkg.sv]
// Constants, field layouts and carrier types for the smart card pin control block.
// Assumes a 100 MHz system clock and an Avalon-MM register master.
// Notes on behaviour
// - Normal mode: host reset reaches card when selected
// - Card reset holds last value while deselected
// - Program-select low: reset input only programs
// - Serial translator active only while selected
// - Serial line value held while deselected
// - Alert low on insertion, removal, battery-low or supply events
// - Alert released on chip-select or power rise
// - Alert is open-collector, wired-AND capable
// - Card clock is source divided 1,2,4,8
// - Card clock stoppable high or low
// - Default detect: normally-open, falling means inserted
// - Detect polarity programmable to normally-closed
// - Card reset enabled only when powered, normal
// - Card reset grounded when card deactivated
// - Register keeps previous host serial state
// - Undervoltage only reported, supply left running
// - Overload: supply off, alert, fault recorded
// - Presence input debounced 50 us both ways
// - Host inputs ignored while chip-select high
// - Host data captured on chip-select rising edge
// - Presence status: high present, low absent
package scpc_pkg;
    localparam int          CLK_PERIOD_NS = 10;
    localparam int          DEB_TIME_NS   = 50000;
    localparam int          DEB_CYCLES    = (DEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Byte addresses of the register words
    localparam logic [3:0]  REG_CTRL      = 4'h0;
    localparam logic [3:0]  REG_STAT      = 4'h4;
    // Control word fields
    localparam int          CTRL_DIV_LO   = 0;
    localparam int          CTRL_STOP_EN  = 2;
    localparam int          CTRL_STOP_LVL = 3;
    localparam int          CTRL_DET_NC   = 4;
    // Divide codes
    localparam logic [1:0]  DIV_BY1       = 2'h0;
    localparam logic [1:0]  DIV_BY2       = 2'h1;
    localparam logic [1:0]  DIV_BY4       = 2'h2;
    localparam logic [1:0]  DIV_BY8       = 2'h3;
    // Pin programming targets and status pin selections, by address pins
    localparam logic [1:0]  PRG_CLOCK     = 2'h0;
    localparam logic [1:0]  PRG_STOP      = 2'h1;
    localparam logic [1:0]  PRG_DETECT    = 2'h2;
    localparam logic [1:0]  STS_PRESENT   = 2'h0;
    localparam logic [1:0]  STS_BATTERY   = 2'h1;
    localparam logic [1:0]  STS_SUPPLY    = 2'h2;
    localparam logic [1:0]  STS_FAULT     = 2'h3;

    typedef struct packed {
        logic [1:0] div;
        logic       stop_en;
        logic       stop_lvl;
    } scpc_clk_cfg_type;

    localparam scpc_clk_cfg_type CLK_CFG_RST = '{div: DIV_BY1, stop_en: 1'b0, stop_lvl: 1'b0};

    typedef enum logic [1:0] {SER_IDLE, SER_HOST, SER_CARD} scpc_ser_type;
endpackage : scpc_pkg

// [scpc_top.sv]
// Pin control of a smart card coupler: reset and serial pass-through, card clock
// selector, presence debounce, open-collector alert and supply fault handling.
// Host pins are synchronous to clk_sys; source_clock is sampled, not a clock domain.
`timescale 1ns/100ps
module scpc_top #(
    parameter int DEB_CYCLES = scpc_pkg::DEB_CYCLES
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        chip_select_n,
    input  wire logic        program_select_n,
    input  wire logic        card_power_request,
    input  wire logic        addr_sel_lo,
    input  wire logic        addr_sel_hi,
    input  wire logic        host_reset_in,
    input  wire logic        host_serial_i,
    output logic             host_serial_o,
    output logic             host_serial_oe,
    output logic             host_alert_o,
    output logic             host_alert_oe,
    output logic             status_out,
    input  wire logic        source_clock,
    output logic             card_clock_out,
    output logic             card_reset_out,
    input  wire logic        card_serial_i,
    output logic             card_serial_o,
    output logic             card_serial_oe,
    output logic             card_supply_enable,
    input  wire logic        card_presence_input,
    input  wire logic        card_supply_undervoltage,
    input  wire logic        card_supply_overload,
    input  wire logic        battery_low
);
    import scpc_pkg::*;

    localparam int CW = $clog2(DEB_CYCLES + 1);

    function automatic logic [1:0] half_last(input logic [1:0] div);
        unique case (div)
            DIV_BY8: half_last = 2'h3;
            DIV_BY4: half_last = 2'h1;
            default: half_last = 2'h0;
        endcase
    endfunction : half_last

    logic cs_q_reg, pwr_q_reg, src_q_reg, uv_q_reg, ovl_q_reg, bat_q_reg;
    logic prog_mode_reg, cap_rst_reg, cap_ser_reg, held_reg;
    logic [1:0] cap_addr_reg, sts_sel_reg, clk_cnt_reg;
    logic det_nc_reg, present_reg, fault_reg, alert_reg;
    logic [CW-1:0] deb_cnt_reg;
    scpc_clk_cfg_type pend_reg, act_reg, pend_next;
    scpc_ser_type ser_reg, ser_next;
    logic [31:0] rdata_next;

    // Edge detection and gating of the host-side inputs
    wire cs_low     = ~chip_select_n;
    wire cs_rise    = chip_select_n & ~cs_q_reg;
    wire cs_fall    = cs_low & cs_q_reg;
    wire pwr_rise   = cs_low & card_power_request & ~pwr_q_reg;
    wire pwr_fall   = cs_low & ~card_power_request & pwr_q_reg;
    wire prog_take  = cs_rise & prog_mode_reg;
    wire link_on    = cs_low & program_select_n & card_supply_enable;
    wire rst_fwd    = cs_low & program_select_n & card_power_request;
    wire ovl_event  = card_supply_overload & ~ovl_q_reg & card_supply_enable;
    wire uv_event   = card_supply_undervoltage & ~uv_q_reg;
    wire bat_event  = battery_low & ~bat_q_reg;

    // Presence debounce
    wire present_raw = det_nc_reg ? card_presence_input : ~card_presence_input;
    wire deb_diff    = present_raw != present_reg;
    wire deb_done    = deb_diff & (deb_cnt_reg == CW'(DEB_CYCLES - 1));
    wire alert_set   = deb_done | bat_event | uv_event | ovl_event;
    wire alert_clr   = cs_rise | pwr_rise;

    // Bus decode
    wire bus_req   = avs_read | avs_write;
    wire bus_take  = bus_req & ~avs_waitrequest;
    wire wr_ctrl   = bus_take & avs_write & (avs_address == REG_CTRL);
    wire prog_det  = prog_take & (cap_addr_reg == PRG_DETECT);
    wire [31:0] ctrl_word = {27'h0, det_nc_reg, pend_reg.stop_lvl, pend_reg.stop_en, pend_reg.div};
    wire [31:0] stat_word = {26'h0, battery_low, alert_reg, fault_reg,
                             card_supply_undervoltage, card_supply_enable, present_reg};

    always_comb begin
        rdata_next = 32'h0;
        if (avs_address == REG_CTRL) begin
            rdata_next = ctrl_word;
        end else if (avs_address == REG_STAT) begin
            rdata_next = stat_word;
        end
    end

    // Pending clock setting: pin programming outranks a bus write in the same cycle
    always_comb begin
        pend_next = pend_reg;
        if (prog_take && cap_addr_reg == PRG_CLOCK) begin
            pend_next.div = {cap_rst_reg, cap_ser_reg};
        end else if (prog_take && cap_addr_reg == PRG_STOP) begin
            pend_next.stop_en  = cap_rst_reg;
            pend_next.stop_lvl = cap_ser_reg;
        end else if (wr_ctrl) begin
            pend_next.div      = avs_writedata[CTRL_DIV_LO +: 2];
            pend_next.stop_en  = avs_writedata[CTRL_STOP_EN];
            pend_next.stop_lvl = avs_writedata[CTRL_STOP_LVL];
        end
    end

    // Card clock selector; a new setting lands as a low phase ends, or on any source rising edge while stopped
    wire src_rise  = source_clock & ~src_q_reg;
    wire tog_now   = src_rise & (clk_cnt_reg == half_last(act_reg.div));
    wire run_one   = act_reg.div == DIV_BY1;
    wire boundary  = (act_reg.stop_en | run_one) ? src_rise : (tog_now & ~card_clock_out);

    // Serial direction: whichever side pulls low first owns the line until release
    always_comb begin
        ser_next = ser_reg;
        unique case (ser_reg)
            SER_IDLE: begin
                if (link_on && !host_serial_i) begin
                    ser_next = SER_HOST;
                // Our own held drive on the card line must not read back as the card talking
                end else if (link_on && !card_serial_i && !card_serial_oe) begin
                    ser_next = SER_CARD;
                end
            end
            SER_HOST: begin
                if (!link_on || host_serial_i) begin
                    ser_next = SER_IDLE;
                end
            end
            SER_CARD: begin
                if (!link_on || card_serial_i) begin
                    ser_next = SER_IDLE;
                end
            end
            default: begin
                ser_next = SER_IDLE;
            end
        endcase
    end

    wire card_drive = card_supply_enable & (link_on ? (ser_next == SER_HOST) : ~held_reg);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            {cs_q_reg, pwr_q_reg, src_q_reg} <= 3'h4;
            {uv_q_reg, ovl_q_reg, bat_q_reg} <= 3'h0;
        end else begin
            {cs_q_reg, pwr_q_reg, src_q_reg} <= {chip_select_n, card_power_request, source_clock};
            {uv_q_reg, ovl_q_reg, bat_q_reg} <= {card_supply_undervoltage, card_supply_overload,
                                                 battery_low};
        end
    end

    // Host capture and programming mode
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prog_mode_reg <= 1'b0;
            cap_addr_reg  <= 2'h0;
            {cap_rst_reg, cap_ser_reg, held_reg} <= 3'h1;
            sts_sel_reg   <= STS_PRESENT;
            det_nc_reg    <= 1'b0;
        end else begin
            if (cs_fall) begin
                prog_mode_reg <= ~program_select_n;
            end
            if (cs_low) begin
                cap_addr_reg <= {addr_sel_hi, addr_sel_lo};
                cap_rst_reg  <= host_reset_in;
                cap_ser_reg  <= host_serial_i;
            end
            if (link_on) begin
                held_reg <= host_serial_i;
            end
            if (cs_rise && !prog_mode_reg) begin
                sts_sel_reg <= cap_addr_reg;
            end
            if (prog_det) begin
                det_nc_reg <= cap_rst_reg;
            end else if (wr_ctrl) begin
                det_nc_reg <= avs_writedata[CTRL_DET_NC];
            end
        end
    end

    // Supply, faults, alert and presence
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            card_supply_enable <= 1'b0;
            fault_reg          <= 1'b0;
            alert_reg          <= 1'b0;
            present_reg        <= 1'b0;
            deb_cnt_reg        <= '0;
        end else begin
            if (ovl_event) begin
                card_supply_enable <= 1'b0;
            end else if (pwr_rise && !card_supply_overload) begin
                card_supply_enable <= 1'b1;
            end else if (pwr_fall) begin
                card_supply_enable <= 1'b0;
            end
            fault_reg   <= ovl_event | (fault_reg & ~pwr_rise);
            alert_reg   <= alert_set | (alert_reg & ~alert_clr);
            deb_cnt_reg <= (deb_diff && !deb_done) ? deb_cnt_reg + 1'b1 : '0;
            if (deb_done) begin
                present_reg <= present_raw;
            end
        end
    end

    // Card-side pins and status pin
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            card_reset_out <= 1'b0;
            ser_reg        <= SER_IDLE;
            card_serial_oe <= 1'b0;
            host_serial_oe <= 1'b0;
            card_serial_o  <= 1'b0;
            host_serial_o  <= 1'b0;
            host_alert_o   <= 1'b0;
            host_alert_oe  <= 1'b0;
            status_out     <= 1'b0;
        end else begin
            if (!card_supply_enable) begin
                card_reset_out <= 1'b0;
            end else if (rst_fwd) begin
                card_reset_out <= host_reset_in;
            end
            ser_reg        <= ser_next;
            card_serial_oe <= card_drive;
            host_serial_oe <= link_on & (ser_next == SER_CARD);
            // Open collector: only ever pulls low, released means high impedance
            host_alert_oe  <= alert_set | (alert_reg & ~alert_clr);
            if (!prog_mode_reg) begin
                unique case (sts_sel_reg)
                    STS_PRESENT: status_out <= present_reg;
                    STS_BATTERY: status_out <= ~battery_low;
                    STS_SUPPLY:  status_out <= card_supply_enable & ~card_supply_undervoltage;
                    STS_FAULT:   status_out <= ~fault_reg;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pend_reg       <= CLK_CFG_RST;
            act_reg        <= CLK_CFG_RST;
            clk_cnt_reg    <= 2'h0;
            card_clock_out <= 1'b0;
        end else begin
            pend_reg <= pend_next;
            if (boundary) begin
                act_reg        <= pend_reg;
                clk_cnt_reg    <= 2'h0;
                card_clock_out <= pend_reg.stop_en ? pend_reg.stop_lvl : 1'b1;
            end else if (!act_reg.stop_en && run_one) begin
                card_clock_out <= source_clock;
            end else if (!act_reg.stop_en && src_rise) begin
                clk_cnt_reg    <= tog_now ? 2'h0 : clk_cnt_reg + 2'h1;
                card_clock_out <= card_clock_out ^ tog_now;
            end
        end
    end

    // Avalon slave: one wait cycle, answer on the following edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0;
        end else begin
            avs_waitrequest <= ~(bus_req & avs_waitrequest);
            if (bus_req && avs_waitrequest) begin
                avs_readdata <= rdata_next;
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_cs_release;
        !chip_select_n ##1 chip_select_n;
    endsequence

    a_reset_forward: assert property (card_supply_enable && rst_fwd
        |=> card_reset_out == $past(host_reset_in)) else $error("card reset not forwarded");
    a_reset_hold: assert property (chip_select_n && card_supply_enable
        |=> $stable(card_reset_out)) else $error("card reset moved while deselected");
    a_reset_prog: assert property (!program_select_n
        |=> $stable(card_reset_out) || !card_reset_out) else $error("reset forwarded in program");
    a_reset_ground: assert property (!card_supply_enable
        |=> !card_reset_out) else $error("card reset high while deactivated");
    a_serial_hold: assert property (!link_on && card_supply_enable
        |=> card_serial_oe == !$past(held_reg)) else $error("serial hold lost");
    a_serial_gate: assert property (chip_select_n
        |=> !host_serial_oe) else $error("host serial driven while deselected");
    a_alert_set: assert property (alert_set
        |=> host_alert_oe && !host_alert_o) else $error("alert not raised");
    a_alert_clear: assert property (s_cs_release and (##1 !alert_set)
        |=> !host_alert_oe) else $error("alert not released");
    a_alert_drain: assert property (!host_alert_o) else $error("alert drove high");
    a_overload_off: assert property (ovl_event
        |=> !card_supply_enable ##0 fault_reg ##0 host_alert_oe) else $error("overload missed");
    a_uv_keeps: assert property (uv_event && card_supply_enable && !card_supply_overload && !pwr_fall
        |=> card_supply_enable) else $error("supply stopped on undervoltage");
    a_stop_level: assert property (act_reg.stop_en && !boundary
        |=> $stable(card_clock_out)) else $error("stopped clock moved");
    a_div2_phase: assert property (!act_reg.stop_en && act_reg.div == DIV_BY2 && src_rise && !boundary
        |=> card_clock_out != $past(card_clock_out)) else $error("divide by 2 missed edge");
endmodule : scpc_top

// [scpc_card_model.sv]
// Card-side partner: open-drain card serial line with pull-up, and a card clock monitor.
// Assumes card pins are synchronous to clk_sys; card_pull is commanded by the bench.
`timescale 1ns/100ps
module scpc_card_model (
    input  wire logic clk_sys,
    input  wire logic card_clock_out,
    input  wire logic card_serial_oe,
    input  wire logic card_pull,
    output logic      card_serial_i,
    output int        clk_period
);
    logic clk_q = 1'b0;
    int   cnt   = 0;

    // Released line floats to the pull-up level; either side pulling low wins
    assign card_serial_i = ~(card_serial_oe | card_pull);

    // Clock cycles between rising edges of the card clock
    always @(posedge clk_sys) begin
        clk_q <= card_clock_out;
        cnt   <= cnt + 1;
        if (card_clock_out && !clk_q) begin
            clk_period <= cnt + 1;
            cnt        <= 0;
        end
    end
endmodule : scpc_card_model

// [scpc_top_tb_top.sv]
// Self-checking bench for the smart card pin control block.
// Bench is the host: Avalon master and host pins on clk_sys; a card model sits on the card pins.
`timescale 1ns/100ps
module scpc_top_tb_top;
    import scpc_pkg::*;
    logic        clk_sys, rst_n, avs_read, avs_write, chip_select_n, program_select_n;
    logic        card_power_request, addr_sel_lo, addr_sel_hi, host_reset_in, host_pull;
    logic        source_clock, card_presence_input, card_supply_undervoltage, card_pull;
    logic        card_supply_overload, battery_low, avs_waitrequest, host_serial_i;
    logic        host_serial_o, host_serial_oe, host_alert_o, host_alert_oe, status_out;
    logic        card_clock_out, card_reset_out, card_serial_i, card_serial_o;
    logic        card_serial_oe, card_supply_enable;
    logic [3:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    int          err_count, cmp_count, period;

    // Host line pull-up: bench or block pulling low wins
    assign host_serial_i = ~(host_pull | host_serial_oe);

    scpc_top #(.DEB_CYCLES(8)) dut_u (
        .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .chip_select_n(chip_select_n),
        .program_select_n(program_select_n), .card_power_request(card_power_request),
        .addr_sel_lo(addr_sel_lo), .addr_sel_hi(addr_sel_hi), .host_reset_in(host_reset_in),
        .host_serial_i(host_serial_i), .host_serial_o(host_serial_o),
        .host_serial_oe(host_serial_oe), .host_alert_o(host_alert_o),
        .host_alert_oe(host_alert_oe), .status_out(status_out), .source_clock(source_clock),
        .card_clock_out(card_clock_out), .card_reset_out(card_reset_out),
        .card_serial_i(card_serial_i), .card_serial_o(card_serial_o),
        .card_serial_oe(card_serial_oe), .card_supply_enable(card_supply_enable),
        .card_presence_input(card_presence_input),
        .card_supply_undervoltage(card_supply_undervoltage),
        .card_supply_overload(card_supply_overload), .battery_low(battery_low));

    scpc_card_model card_u (.clk_sys(clk_sys), .card_clock_out(card_clock_out),
        .card_serial_oe(card_serial_oe), .card_pull(card_pull),
        .card_serial_i(card_serial_i), .clk_period(period));

    initial clk_sys = 1'b0;
    always #5 clk_sys = ~clk_sys;
    // Source clock of 8 system cycles, offset from the system edges
    initial begin
        source_clock = 1'b0;
        #3;
        forever #40 source_clock = ~source_clock;
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk

    task cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc

    task look(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : look

    // Request held until waitrequest is seen low at a rising edge
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        avs_address   <= a;
        avs_writedata <= wd;
        avs_write     <= wr;
        avs_read      <= ~wr;
        // Values read at the edge are those that stood just before it; a hang is the watchdog's
        do begin
            @(posedge clk_sys);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task rdchk(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdchk

    // One chip-select frame with the given mode, address pins and data pins
    task pins(input logic pg, input logic [1:0] a, input logic r, input logic s);
        @(posedge clk_sys);
        program_select_n           <= pg;
        {addr_sel_hi, addr_sel_lo} <= a;
        host_reset_in              <= r;
        host_pull                  <= ~s;
        chip_select_n              <= 1'b0;
        cyc(3);
        chip_select_n <= 1'b1;
        cyc(3);
        program_select_n <= 1'b1;
        host_pull        <= 1'b0;
    endtask : pins

    task end_sim;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim

    initial begin
        #300000;
        err_count++;
        $display("Error at %0t: watchdog expired", $time);
        end_sim;
    end

    initial begin
        err_count = 0;
        cmp_count = 0;
        rst_n     = 1'b0;
        {avs_read, avs_write, card_pull, host_pull, card_power_request, host_reset_in} = '0;
        {addr_sel_lo, addr_sel_hi, card_supply_undervoltage, card_supply_overload} = '0;
        {battery_low, avs_address, avs_writedata} = '0;
        {chip_select_n, program_select_n, card_presence_input} = 3'b111;
        cyc(20);
        rst_n <= 1'b1;
        look(1);
        chk(card_reset_out, 1'b0);
        rdchk(REG_CTRL, 32'h0);
        rdchk(REG_STAT, 32'h0);
        bus(1'b1, REG_STAT, 32'hFF);
        bus(1'b1, 4'h8, 32'hFF);
        rdchk(REG_STAT, 32'h0);
        rdchk(4'h8, 32'h0);
        rdchk(REG_CTRL, 32'h0);
        $display("Test reset and map done");

        for (int i = 0; i < 4; i++) begin
            bus(1'b1, REG_CTRL, 32'(i));
            cyc(300);
            chk(32'(period), 32'(8 << i));
        end
        for (int l = 0; l < 2; l++) begin
            bus(1'b1, REG_CTRL, 32'(4 + 8 * l));
            cyc(200);
            for (int j = 0; j < 8; j++) begin
                look(9);
                chk(card_clock_out, 32'(l));
            end
        end
        bus(1'b1, REG_CTRL, 32'h0);
        $display("Test card clock done");

        card_presence_input <= 1'b0;
        look(3);
        chk(host_alert_oe, 1'b0);
        look(40);
        chk(host_alert_oe, 1'b1);
        rdchk(REG_STAT, 32'h11);
        pins(1'b1, STS_PRESENT, 1'b0, 1'b1);
        look(0);
        chk(status_out, 1'b1);
        chk(host_alert_oe, 1'b0);
        $display("Test insertion done");

        cyc(1);
        chip_select_n <= 1'b0;
        cyc(2);
        card_power_request <= 1'b1;
        host_reset_in      <= 1'b1;
        look(4);
        chk(card_reset_out, 1'b1);
        cyc(1);
        chip_select_n <= 1'b1;
        cyc(2);
        host_reset_in      <= 1'b0;
        card_power_request <= 1'b0;
        look(4);
        chk(card_reset_out, 1'b1);
        chk(card_supply_enable, 1'b1);
        cyc(1);
        card_power_request <= 1'b1;
        chip_select_n      <= 1'b0;
        host_pull          <= 1'b1;
        look(3);
        chk(card_serial_oe, 1'b1);
        cyc(1);
        chip_select_n <= 1'b1;
        cyc(2);
        host_pull <= 1'b0;
        look(3);
        chk(card_serial_oe, 1'b1);
        cyc(1);
        chip_select_n <= 1'b0;
        look(3);
        chk(card_serial_oe, 1'b0);
        cyc(1);
        card_pull <= 1'b1;
        look(3);
        chk(host_serial_oe, 1'b1);
        cyc(1);
        card_pull <= 1'b0;
        $display("Test reset and serial done");

        host_reset_in            <= 1'b1;
        card_supply_undervoltage <= 1'b1;
        look(4);
        chk(card_supply_enable, 1'b1);
        chk(card_reset_out, 1'b1);
        rdchk(REG_STAT, 32'h17);
        card_supply_undervoltage <= 1'b0;
        card_supply_overload     <= 1'b1;
        look(4);
        chk(card_supply_enable, 1'b0);
        chk(card_reset_out, 1'b0);
        rdchk(REG_STAT, 32'h19);
        card_supply_overload <= 1'b0;
        chip_select_n        <= 1'b1;
        host_reset_in        <= 1'b0;
        look(3);
        chk(host_alert_oe, 1'b0);
        cyc(1);
        battery_low <= 1'b1;
        look(3);
        chk(host_alert_oe, 1'b1);
        chk({host_serial_o, card_serial_o}, 2'b00);
        $display("Test supply faults done");

        // Power the card again so that a reset leaking through in program mode would show
        cyc(1);
        chip_select_n      <= 1'b0;
        card_power_request <= 1'b0;
        cyc(2);
        card_power_request <= 1'b1;
        look(3);
        chk(card_supply_enable, 1'b1);
        cyc(1);
        chip_select_n <= 1'b1;
        pins(1'b0, PRG_CLOCK, 1'b1, 1'b1);
        chk(card_reset_out, 1'b0);
        rdchk(REG_CTRL, 32'h3);
        pins(1'b0, PRG_STOP, 1'b1, 1'b1);
        rdchk(REG_CTRL, 32'hF);
        look(150);
        chk(card_clock_out, 1'b1);
        pins(1'b0, PRG_DETECT, 1'b1, 1'b0);
        pins(1'b0, 2'h3, 1'b0, 1'b0);
        rdchk(REG_CTRL, 32'h1F);
        card_presence_input <= 1'b1;
        cyc(40);
        bus(1'b0, REG_STAT, 32'h0);
        chk(rd[0], 1'b1);
        chk(host_alert_o, 1'b0);
        chk(host_alert_oe, 1'b1);
        $display("Test pin programming done");
        end_sim;
    end
endmodule : scpc_top_tb_top
